//--- common/lpm_ext_if.sv
// interface: external-request conditioning between top and edge unit
`timescale 1ns/1ps
interface lpm_ext_if;
   logic pin_sync;
   logic [1:0] trig_sel;
   logic gate;
   logic flush;
   logic pending;
   logic ack;
   modport ctrl (output trig_sel, output gate, output flush, output ack, input pending, input pin_sync);
   modport unit (input trig_sel, input gate, input flush, input ack, output pending, output pin_sync);
endinterface

//--- common/lpm_pkg.sv
// package: constants and types for the low-power mode controller
package lpm_pkg;
   // register map (byte address)
   localparam logic [7:0] LPM_MISC_OFF = 8'h0c;
   localparam logic [7:0] LPM_CTRL_OFF = 8'h10;
   localparam logic [7:0] LPM_STAT_OFF = 8'h14;
   // misc register field positions
   localparam int LPM_POR_BIT = 7;
   localparam int LPM_RISE_BIT = 6;
   localparam int LPM_FALL_BIT = 5;
   localparam int LPM_GATE_BIT = 4;
   localparam int LPM_SFA_BIT = 3;
   localparam int LPM_SFB_BIT = 2;
   localparam int LPM_SLOW_BIT = 1;
   localparam int LPM_WDOG_BIT = 0;
   // ctrl register field positions
   localparam int LPM_CMD_STOP_BIT = 0;
   localparam int LPM_CMD_WAIT_BIT = 1;
   localparam int LPM_IMASK_SET_BIT = 2;
   localparam int LPM_IMASK_CLR_BIT = 3;
   // reset values: u001 000u, undefined bits taken as zero
   localparam logic [7:0] LPM_MISC_RST = 8'h10;
   // settle delay choices in internal cycles
   localparam int LPM_SETTLE_SHORT = 16;
   localparam int LPM_SETTLE_LONG = 4064;
   localparam logic [11:0] LPM_SETTLE_SHORT_C = 12'(LPM_SETTLE_SHORT);
   localparam logic [11:0] LPM_SETTLE_LONG_C = 12'(LPM_SETTLE_LONG);
   // slow divider ratio
   localparam int LPM_SLOW_DIV = 16;
   localparam logic [3:0] LPM_SLOW_DIV_MAX = 4'(LPM_SLOW_DIV - 1);
   // vector addresses
   localparam logic [15:0] LPM_VEC_INT = 16'h3ffa;
   localparam logic [15:0] LPM_VEC_RST = 16'h3ffe;
   // watchdog reset pulse count loaded on timeout; the reset pin is driven one cycle longer than this
   localparam logic [3:0] LPM_WDOG_PULSE = 4'h8;
   typedef enum logic [2:0] {
      LPM_RUN, LPM_STOPPED, LPM_SETTLE, LPM_WAITING, LPM_STACK
   } lpm_state_e;
endpackage

//--- core/lpm_ctrl.sv
// top: low-power mode controller with APB register access
// Notes on behaviour
// - stop accepted only while CAN module sleeps
// - stop wake by CAN, wired-OR, ext req, reset
// - stop entry clears the interrupt mask bit
// - stop entry clears the slow divider bit
// - hold CPU for 16 or 4064 settle cycles
// - vector interrupt pair or reset pair after settle; code skips settle on reset exit
// - stack only after leaving low-power state
// - stop resets watchdog, freezes peripherals, disables converter
// - other state held unchanged during stop
// - wait stops CPU, peripherals keep running
// - wait clears mask, keeps ext gate bit
// - any interrupt or reset ends wait
// - reset exit returns system to reset state
// - slow bit adds divide-by-16 to bus clock
// - slow divider never touches CAN clock
// - reset clears slow bit, misc reset u001000u
// - trigger option writes only with mask set
// - changed trigger option clears pending request
// - cleared gate bit ignores external request pin
// - reset pin low resets; watchdog drives it
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module lpm_ctrl
   import lpm_pkg::*;
#(
   parameter int SETTLE_LONG = LPM_SETTLE_LONG
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic settle_long_opt,
   input wire logic wdog_wait_opt,
   input wire logic can_asleep,
   input wire logic can_irq,
   input wire logic wired_or_irq,
   input wire logic ext_req_n,
   input wire logic wdog_timeout,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic cpu_clk_en,
   output logic bus_tick,
   output logic periph_clk_en,
   output logic wdog_clear,
   output logic wdog_run,
   output logic nvm_read_only,
   output logic adc_enable,
   output logic can_clk_en,
   output logic irq_mask,
   output logic stack_req,
   output logic [15:0] vector_addr,
   output logic sys_reset_n
);
   import lpm_pkg::*;

   localparam logic [11:0] SETTLE_LONG_C = 12'(SETTLE_LONG);

   lpm_ext_if ext ();
   lpm_state_e state_r, state_nxt;
   logic [7:0] misc_r, misc_nxt;
   logic imask_r, imask_nxt;
   logic [11:0] settle_r, settle_nxt;
   logic wake_irq_r, wake_irq_nxt;
   logic [2:0] rst_sync_r;
   logic rst_lvl_r;
   logic [3:0] wd_cnt_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   logic cpu_en_r, per_en_r, wdclr_r, wdrun_r, nvm_ro_r, adc_en_r;
   logic stack_r, sysrst_r, rpin_oe_r, tick_r;
   logic [15:0] vec_r;
   logic slow_tick;

   // apb decode: single wait-free access phase
   logic acc_w, wr_w, rd_w, hit_misc, hit_ctrl, hit_stat, hit_any;
   assign acc_w = psel & penable;
   assign wr_w = acc_w & pwrite;
   assign rd_w = acc_w & ~pwrite;
   assign hit_misc = paddr == LPM_MISC_OFF;
   assign hit_ctrl = paddr == LPM_CTRL_OFF;
   assign hit_stat = paddr == LPM_STAT_OFF;
   assign hit_any = hit_misc | hit_ctrl | hit_stat;

   // command strobes from the ctrl register (write-one pulses)
   logic cmd_stop, cmd_wait, cmd_iset, cmd_iclr;
   assign cmd_stop = wr_w & hit_ctrl & pwdata[LPM_CMD_STOP_BIT];
   assign cmd_wait = wr_w & hit_ctrl & pwdata[LPM_CMD_WAIT_BIT];
   assign cmd_iset = wr_w & hit_ctrl & pwdata[LPM_IMASK_SET_BIT];
   assign cmd_iclr = wr_w & hit_ctrl & pwdata[LPM_IMASK_CLR_BIT];

   // reset pin: three flops, level follows once stages two and three agree
   logic rst_lvl_nxt, pin_rst;
   assign rst_lvl_nxt = (rst_sync_r[1] == rst_sync_r[2]) ? rst_sync_r[2] : rst_lvl_r;
   assign pin_rst = ~rst_lvl_r & ~rpin_oe_r;

   // wake sources; the ext request only counts when gated in
   logic ext_wake, irq_any;
   assign ext_wake = ext.pending & misc_r[LPM_GATE_BIT];
   assign irq_any = can_irq | wired_or_irq | ext_wake;

   // misc write: trigger bits only while mask set, slow bit writable
   logic [1:0] trig_cur, trig_new;
   logic trig_we;
   assign trig_cur = {misc_r[LPM_RISE_BIT], misc_r[LPM_FALL_BIT]};
   assign trig_new = {pwdata[LPM_RISE_BIT], pwdata[LPM_FALL_BIT]};
   assign trig_we = wr_w & hit_misc & imask_r;
   assign ext.flush = trig_we & (trig_new != trig_cur);
   assign ext.trig_sel = trig_cur;
   assign ext.gate = misc_r[LPM_GATE_BIT];
   // the stacking cycle of any wake retires a latched request, so it cannot re-wake the next wait
   assign ext.ack = stack_r;

   // stop is only taken while the CAN module sleeps
   logic stop_go;
   assign stop_go = cmd_stop & can_asleep & (state_r == LPM_RUN);

   // settle target chosen by the settle_long_opt input
   logic [11:0] settle_tgt;
   assign settle_tgt = settle_long_opt ? SETTLE_LONG_C : LPM_SETTLE_SHORT_C;

   // next-state logic for mode sequencer
   always_comb begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      wake_irq_nxt = wake_irq_r;
      unique case (state_r)
         LPM_RUN: begin
            if (stop_go) begin
               state_nxt = LPM_STOPPED;
            end else if (cmd_wait) begin
               state_nxt = LPM_WAITING;
            end
         end
         LPM_STOPPED: begin
            settle_nxt = 12'h0;
            if (irq_any) begin
               state_nxt = LPM_SETTLE;
               wake_irq_nxt = 1'b1;
            end
         end
         LPM_SETTLE: begin
            // counts full-speed cycles; slow bit is already clear here
            settle_nxt = settle_r + 12'h1;
            if (settle_r + 12'h1 >= settle_tgt) begin
               state_nxt = LPM_STACK;
            end
         end
         LPM_WAITING: begin
            if (irq_any) begin
               state_nxt = LPM_STACK;
               wake_irq_nxt = 1'b1;
            end
         end
         LPM_STACK: begin
            state_nxt = LPM_RUN;
            wake_irq_nxt = 1'b0;
         end
      endcase
   end

   // misc register next value
   always_comb begin
      misc_nxt = misc_r;
      if (wr_w && hit_misc) begin
         misc_nxt[LPM_GATE_BIT] = pwdata[LPM_GATE_BIT];
         misc_nxt[LPM_SFA_BIT] = pwdata[LPM_SFA_BIT];
         misc_nxt[LPM_SFB_BIT] = pwdata[LPM_SFB_BIT];
         misc_nxt[LPM_SLOW_BIT] = pwdata[LPM_SLOW_BIT];
         if (imask_r) begin
            misc_nxt[LPM_RISE_BIT] = pwdata[LPM_RISE_BIT];
            misc_nxt[LPM_FALL_BIT] = pwdata[LPM_FALL_BIT];
         end
      end
      if (stop_go) begin
         misc_nxt[LPM_SLOW_BIT] = 1'b0;
      end
      misc_nxt[LPM_POR_BIT] = 1'b0;
      misc_nxt[LPM_WDOG_BIT] = 1'b0;
   end

   // interrupt mask: cleared on entry to stop or wait, set when vectoring
   always_comb begin
      imask_nxt = imask_r;
      if (cmd_iclr) begin
         imask_nxt = 1'b0;
      end
      if (cmd_iset) begin
         imask_nxt = 1'b1;
      end
      if (stop_go) begin
         imask_nxt = 1'b0;
      end else if (state_r == LPM_RUN && cmd_wait) begin
         imask_nxt = 1'b0;
      end
      if (state_r == LPM_STACK) begin
         imask_nxt = 1'b1;
      end
   end

   // mode sequencer, registers; reset pin or watchdog returns all to reset state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= LPM_RUN;
         settle_r <= 12'h0;
         wake_irq_r <= 1'b0;
         misc_r <= LPM_MISC_RST;
         imask_r <= 1'b1;
      end else if (pin_rst) begin
         state_r <= LPM_RUN;
         settle_r <= 12'h0;
         wake_irq_r <= 1'b0;
         misc_r <= LPM_MISC_RST;
         imask_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         settle_r <= settle_nxt;
         wake_irq_r <= wake_irq_nxt;
         misc_r <= misc_nxt;
         imask_r <= imask_nxt;
      end
   end

   // reset pin synchroniser and watchdog open-drain pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync_r <= 3'h7;
         rst_lvl_r <= 1'b1;
         wd_cnt_r <= 4'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[1:0], reset_pin_in};
         rst_lvl_r <= rst_lvl_nxt;
         if (wdog_timeout) begin
            wd_cnt_r <= LPM_WDOG_PULSE;
         end else if (wd_cnt_r != 4'h0) begin
            wd_cnt_r <= wd_cnt_r - 4'h1;
         end
      end
   end

   // clock gates and module controls, all registered
   logic in_stop, in_wait, cpu_on;
   assign in_stop = (state_r == LPM_STOPPED) || (state_r == LPM_SETTLE);
   assign in_wait = state_r == LPM_WAITING;
   assign cpu_on = (state_nxt == LPM_RUN) || (state_nxt == LPM_STACK);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_en_r <= 1'b0;
         per_en_r <= 1'b0;
         wdclr_r <= 1'b1;
         wdrun_r <= 1'b0;
         nvm_ro_r <= 1'b0;
         adc_en_r <= 1'b0;
         stack_r <= 1'b0;
         vec_r <= LPM_VEC_RST;
         sysrst_r <= 1'b0;
         rpin_oe_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         cpu_en_r <= cpu_on & ~pin_rst;
         per_en_r <= ~in_stop & ~pin_rst;
         wdclr_r <= in_stop | pin_rst;
         wdrun_r <= ~in_stop & ~(in_wait & ~wdog_wait_opt);
         nvm_ro_r <= in_stop;
         adc_en_r <= ~in_stop & ~pin_rst;
         stack_r <= (state_nxt == LPM_STACK) & ~pin_rst;
         vec_r <= (pin_rst || state_nxt != LPM_STACK) ? LPM_VEC_RST : LPM_VEC_INT;
         sysrst_r <= ~pin_rst;
         rpin_oe_r <= wd_cnt_r != 4'h0 || wdog_timeout;
         tick_r <= slow_tick & ~in_stop;
      end
   end

   // apb read data and answer
   logic [31:0] rd_val;
   assign rd_val = hit_misc ? {24'h0, misc_r} :
                   hit_ctrl ? {28'h0, imask_r, 3'h0} :
                   hit_stat ? {24'h0, ext.pin_sync, ext.pending, can_asleep, 2'h0, state_r} : 32'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= (psel & ~penable & ~pwrite) ? rd_val : prdata_r;
         pready_r <= psel & ~penable;
         pslverr_r <= psel & ~penable & ~hit_any;
      end
   end

   lpm_slow_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .slow(misc_r[LPM_SLOW_BIT]),
      .tick(slow_tick)
   );

   lpm_ext_req u_ext (
      .pclk(pclk),
      .presetn(presetn),
      .ext_req_n(ext_req_n),
      .bus(ext)
   );

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = rpin_oe_r;
   assign cpu_clk_en = cpu_en_r;
   assign bus_tick = tick_r;
   assign periph_clk_en = per_en_r;
   assign wdog_clear = wdclr_r;
   assign wdog_run = wdrun_r;
   assign nvm_read_only = nvm_ro_r;
   assign adc_enable = adc_en_r;
   assign can_clk_en = sysrst_r;
   assign irq_mask = imask_r;
   assign stack_req = stack_r;
   assign vector_addr = vec_r;
   assign sys_reset_n = sysrst_r;
endmodule

//--- core/lpm_ext_req.sv
// module: external request pin synchroniser and trigger detector
`timescale 1ns/1ps
module lpm_ext_req
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ext_req_n,
   lpm_ext_if.unit bus
);
   logic [2:0] sync_r;
   logic level_r;
   logic prev_r;
   logic pend_r;
   logic lvl_nxt;
   logic fall_w;
   logic rise_w;
   logic hit_w;

   // three-stage sync; change accepted when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_r <= 3'h7;
         level_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         sync_r <= {sync_r[1:0], ext_req_n};
         level_r <= lvl_nxt;
         prev_r <= level_r;
      end
   end
   assign lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
   assign bus.pin_sync = level_r;

   // trigger options: falling, rising, both edges, low level
   assign fall_w = prev_r & ~level_r;
   assign rise_w = ~prev_r & level_r;
   assign hit_w = (bus.trig_sel == 2'h0) ? fall_w :
                  (bus.trig_sel == 2'h1) ? rise_w :
                  (bus.trig_sel == 2'h2) ? (fall_w | rise_w) : ~level_r;

   // pending flag; new hit wins over ack, flush on option change wins over all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= 1'b0;
      end else if (bus.flush || !bus.gate) begin
         pend_r <= 1'b0;
      end else if (hit_w) begin
         pend_r <= 1'b1;
      end else if (bus.ack) begin
         pend_r <= 1'b0;
      end
   end
   assign bus.pending = pend_r;
endmodule

//--- core/lpm_slow_div.sv
// module: slow-mode divide-by-16 bus clock enable generator
`timescale 1ns/1ps
module lpm_slow_div
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   output logic tick
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;

   // counter held at zero with a tick each cycle in normal mode; counts and ticks 1 in 16 when slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign cnt_nxt = (!slow || cnt_r == LPM_SLOW_DIV_MAX) ? 4'h0 : cnt_r + 4'h1;
   assign tick = !slow || (cnt_r == LPM_SLOW_DIV_MAX);
endmodule

//--- verification/lpm_ctrl_properties.sv
// checker: port-level properties of the low-power mode controller
`timescale 1ns/1ps
module lpm_ctrl_props
   import lpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic can_asleep,
   input wire logic can_irq,
   input wire logic wdog_timeout,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic cpu_clk_en,
   input wire logic bus_tick,
   input wire logic periph_clk_en,
   input wire logic wdog_clear,
   input wire logic nvm_read_only,
   input wire logic adc_enable,
   input wire logic can_clk_en,
   input wire logic irq_mask,
   input wire logic stack_req,
   input wire logic [15:0] vector_addr,
   input wire logic sys_reset_n
);
   logic stop_wr;
   logic mapped;
   // stop command seen at the access edge; cpu_clk_en marks the run state
   assign stop_wr = psel && penable && pready && pwrite && paddr == LPM_CTRL_OFF && pwdata[LPM_CMD_STOP_BIT];
   assign mapped = paddr == LPM_MISC_OFF || paddr == LPM_CTRL_OFF || paddr == LPM_STAT_OFF;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single access cycle");
   a_unmapped_err: assert property (psel && penable && pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_stop_taken: assert property (stop_wr && can_asleep && cpu_clk_en |=> !irq_mask ##[0:1] !cpu_clk_en)
      else $error("stop not entered");
   a_stop_refused: assert property (stop_wr && !can_asleep && cpu_clk_en |=> cpu_clk_en [*3])
      else $error("stop taken while can module awake");
   a_stop_quiet: assert property (nvm_read_only |-> !adc_enable && !periph_clk_en && wdog_clear && !bus_tick)
      else $error("peripherals active in stop");
   a_can_clock: assert property (!bus_tick && sys_reset_n |-> can_clk_en)
      else $error("can clock gated");
   a_wait_wake: assert property (!cpu_clk_en && periph_clk_en && can_irq |-> ##[1:2] stack_req && vector_addr == LPM_VEC_INT)
      else $error("wait not ended by interrupt");
   a_stack_run: assert property (stack_req |-> cpu_clk_en ##1 !stack_req)
      else $error("stacking while still in low power");
   a_wdog_pin: assert property (wdog_timeout |-> ##[1:2] (reset_pin_oe && !reset_pin_out))
      else $error("watchdog does not pull reset pin");
   a_reset_vec: assert property (!sys_reset_n |-> vector_addr == LPM_VEC_RST)
      else $error("reset vector not selected");
endmodule

bind lpm_ctrl lpm_ctrl_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_asleep(can_asleep),
   .can_irq(can_irq), .wdog_timeout(wdog_timeout), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
   .cpu_clk_en(cpu_clk_en), .bus_tick(bus_tick), .periph_clk_en(periph_clk_en), .wdog_clear(wdog_clear),
   .nvm_read_only(nvm_read_only), .adc_enable(adc_enable), .can_clk_en(can_clk_en), .irq_mask(irq_mask),
   .stack_req(stack_req), .vector_addr(vector_addr), .sys_reset_n(sys_reset_n));

//--- verification/lpm_partner.sv
// partner model: peripheral interrupt sources and the shared reset pin
`timescale 1ns/1ps
module lpm_partner (
   input wire logic pclk,
   input wire logic stack_req,
   input wire logic reset_pin_oe,
   output logic can_irq,
   output logic wired_or_irq,
   output logic reset_pin_in
);
   logic pull_low = 1'b0;
   initial begin
      can_irq = 1'b0;
      wired_or_irq = 1'b0;
   end
   // a source keeps requesting until the cpu stacks it, so a late wake is not lost
   always @(posedge pclk) begin
      if (stack_req) begin
         can_irq <= 1'b0;
         wired_or_irq <= 1'b0;
      end
   end
   // open-drain wire with pull-up: low while either party pulls it
   assign reset_pin_in = !(reset_pin_oe || pull_low);
   task automatic raise(input int src);
      @(posedge pclk);
      if (src == 0) can_irq <= 1'b1;
      else wired_or_irq <= 1'b1;
   endtask
   task automatic pin_reset(input int n);
      @(posedge pclk);
      pull_low <= 1'b1;
      repeat (n) @(posedge pclk);
      pull_low <= 1'b0;
   endtask
endmodule

//--- verification/tb_low_power_mode_control.sv
// testbench: register access, stop, wait and reset scenarios
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_low_power_mode_control;
   import lpm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic settle_long_opt = 1'b0, wdog_wait_opt = 1'b1, can_asleep = 1'b0, ext_req_n = 1'b1, wdog_timeout = 1'b0;
   logic can_irq, wired_or_irq, reset_pin_in, reset_pin_out, reset_pin_oe, cpu_clk_en, bus_tick, periph_clk_en;
   logic wdog_clear, wdog_run, nvm_read_only, adc_enable, can_clk_en, irq_mask, stack_req, sys_reset_n, e;
   logic [15:0] vector_addr, vec_seen;
   int fails = 0, n_tests = 0, cyc = 0, stacks = 0, n;
   // short settle count keeps the long option cheap to simulate
   lpm_ctrl #(.SETTLE_LONG(40)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .settle_long_opt(settle_long_opt), .wdog_wait_opt(wdog_wait_opt), .can_asleep(can_asleep),
      .can_irq(can_irq), .wired_or_irq(wired_or_irq), .ext_req_n(ext_req_n), .wdog_timeout(wdog_timeout),
      .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
      .cpu_clk_en(cpu_clk_en), .bus_tick(bus_tick), .periph_clk_en(periph_clk_en), .wdog_clear(wdog_clear),
      .wdog_run(wdog_run), .nvm_read_only(nvm_read_only), .adc_enable(adc_enable), .can_clk_en(can_clk_en),
      .irq_mask(irq_mask), .stack_req(stack_req), .vector_addr(vector_addr), .sys_reset_n(sys_reset_n));
   lpm_partner prt (.pclk(pclk), .stack_req(stack_req), .reset_pin_oe(reset_pin_oe), .can_irq(can_irq),
      .wired_or_irq(wired_or_irq), .reset_pin_in(reset_pin_in));
   initial begin
      forever #50 pclk = ~pclk;
   end
   // run limit and a tally of stacking pulses, which last one cycle only
   always @(posedge pclk) begin
      cyc++;
      // the vector only stands with the stacking pulse, so keep the one seen there
      if (stack_req === 1'b1) begin
         stacks++;
         vec_seen = vector_addr;
      end
      if (cyc == 20000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // one apb transfer: request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(r, x)
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(LPM_MISC_OFF, 32'h10);
      rd(8'h20, 32'h0);
      `CHK(e, 1'b1)
      wr(LPM_MISC_OFF, 32'h62);
      rd(LPM_MISC_OFF, 32'h62);
      wr(LPM_CTRL_OFF, 32'h8);
      wr(LPM_MISC_OFF, 32'h12);
      rd(LPM_MISC_OFF, 32'h72);
      n = 0;
      repeat (64) @(posedge pclk) n += bus_tick;
      `CHK(n, 4)
      wr(LPM_CTRL_OFF, 32'h1);
      repeat (3) @(posedge pclk);
      `CHK(cpu_clk_en, 1'b1)
      $display("test registers done");
      for (int i = 0; i < 2; i++) begin
         settle_long_opt <= i[0];
         can_asleep <= 1'b1;
         wr(LPM_CTRL_OFF, 32'h4);
         wr(LPM_MISC_OFF, 32'h72);
         wr(LPM_CTRL_OFF, 32'h1);
         repeat (20) @(posedge pclk);
         `CHK({irq_mask, cpu_clk_en, nvm_read_only, wdog_run}, 4'b0010)
         prt.raise(1);
         n = 0;
         while (stack_req !== 1'b1) begin
            @(posedge pclk);
            n++;
         end
         `CHK(n >= (i ? 40 : 16) && n <= (i ? 44 : 20), 1'b1)
         `CHK(vector_addr, LPM_VEC_INT)
         rd(LPM_MISC_OFF, 32'h70);
         $display("test stop done");
      end
      wr(LPM_CTRL_OFF, 32'h4);
      wr(LPM_MISC_OFF, 32'h0);
      wr(LPM_CTRL_OFF, 32'h2);
      repeat (4) @(posedge pclk) ext_req_n <= 1'b0;
      @(posedge pclk) ext_req_n <= 1'b1;
      repeat (10) @(posedge pclk);
      `CHK({cpu_clk_en, periph_clk_en, irq_mask, wdog_run}, 4'b0101)
      rd(LPM_MISC_OFF, 32'h0);
      for (int s = 0; s < 3; s++) begin
         n = stacks;
         if (s == 2) wr(LPM_MISC_OFF, 32'h10);
         if (s != 0) wr(LPM_CTRL_OFF, 32'h2);
         if (s < 2) prt.raise(s);
         else repeat (4) @(posedge pclk) ext_req_n <= 1'b0;
         @(posedge pclk) ext_req_n <= 1'b1;
         repeat (10) @(posedge pclk);
         `CHK({stacks - n, cpu_clk_en, vec_seen}, {32'd1, 1'b1, LPM_VEC_INT})
      end
      rd(LPM_STAT_OFF, 32'ha0);
      $display("test wait done");
      @(posedge pclk) wdog_timeout <= 1'b1;
      @(posedge pclk) wdog_timeout <= 1'b0;
      @(posedge pclk);
      `CHK({reset_pin_oe, reset_pin_out}, 2'b10)
      repeat (30) @(posedge pclk);
      wr(LPM_MISC_OFF, 32'h12);
      wr(LPM_CTRL_OFF, 32'h2);
      prt.pin_reset(6);
      `CHK(sys_reset_n, 1'b0)
      repeat (10) @(posedge pclk);
      rd(LPM_MISC_OFF, 32'h10);
      `CHK({cpu_clk_en, vector_addr}, {1'b1, LPM_VEC_RST})
      $display("test reset done");
      end_of_test();
   end
endmodule
